// ==== block_ram_pkg.sv ====
// Purpose: shared constants for the block ram with fifo option
// Assumes: single 10 MHz system clock, pins sampled into it
// Notes: widths here are defaults; the top module re-exposes them
package block_ram_pkg;
	localparam int DATA_W = 9;
	localparam int ADDR_W = 10;
	localparam int SYNC_STAGES = 3;
	localparam int CLK_PERIOD_NS = 100;

	typedef enum logic [1:0] {
		WR_NORMAL = 2'h0,
		WR_THROUGH = 2'h1,
		WR_READ_FIRST = 2'h3
	} write_mode_t;

	// widths on which the read-before-write option exists
	localparam int RBW_W0 = 9;
	localparam int RBW_W1 = 18;
	localparam int RBW_W2 = 36;

	// flag states after a fifo clear
	localparam logic FULL_RST = 1'b0;
	localparam logic NEAR_FULL_RST = 1'b0;
	localparam logic NEAR_EMPTY_RST = 1'b1;
	localparam logic EMPTY_RST = 1'b1;
	localparam logic [3:0] EMPTY_LEVEL = 4'h0;

	typedef enum logic [1:0] {
		FIFO_IDLE = 2'h0,
		FIFO_PUSH = 2'h1,
		FIFO_POP = 2'h3,
		FIFO_BOTH = 2'h2
	} fifo_op_t;
endpackage

// ==== pin_sync.sv ====
// Purpose: three-stage synchroniser with a filtered level and rise pulse
// Assumes: input is asynchronous to ref_clk
// Notes: stage one feeds only stage two
`timescale 1ns/10ps
module pin_sync (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic pin_in,
	output logic level,
	output logic rise
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else if (ce) begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a change is taken only once stages two and three agree
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			level <= 1'b0;
		end else if (ce && (s2_reg == s3_reg)) begin
			level <= s3_reg;
		end
	end

	assign rise = ce && (s2_reg == s3_reg) && s3_reg && !level;
endmodule

// ==== block_ram_fifo.sv ====
// Purpose: dual-port block ram with write modes and a fifo option
// Assumes: push_clock and pop_clock are slow pins sampled by ref_clk
// Notes: push/pop controls are sampled on the detected clock edge
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module block_ram_fifo #(
	parameter int DATA_W = block_ram_pkg::DATA_W,
	parameter int ADDR_W = block_ram_pkg::ADDR_W
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic fifo_mode,
	input wire logic [1:0] write_mode_a,
	input wire logic [1:0] write_mode_b,
	input wire logic port_a_reset,
	input wire logic port_b_reset,
	input wire logic en_a,
	input wire logic we_a,
	input wire logic [ADDR_W-1:0] addr_a,
	input wire logic [DATA_W-1:0] wdata_a,
	output logic [DATA_W-1:0] rdata_a,
	input wire logic en_b,
	input wire logic we_b,
	input wire logic [ADDR_W-1:0] addr_b,
	input wire logic [DATA_W-1:0] wdata_b,
	output logic [DATA_W-1:0] rdata_b,
	input wire logic push_clock,
	input wire logic push_clock_gate,
	input wire logic push_strobe,
	input wire logic [DATA_W-1:0] push_data,
	input wire logic pop_clock,
	input wire logic pop_clock_gate,
	input wire logic pop_strobe,
	output logic [DATA_W-1:0] pop_data,
	input wire logic [ADDR_W:0] full_level,
	input wire logic [ADDR_W:0] near_full_level,
	input wire logic [ADDR_W:0] near_empty_level,
	output logic full_flag,
	output logic near_full_flag,
	output logic near_empty_flag,
	output logic empty_flag
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [ADDR_W:0] MAX_FULL = (ADDR_W + 1)'(DEPTH - 1);
	localparam logic [ADDR_W:0] ONE = (ADDR_W + 1)'(1);
	localparam logic [ADDR_W:0] ZERO_LVL = (ADDR_W + 1)'(0);
	// read-before-write exists only at three widths
	localparam bit RBW_OK = (DATA_W == block_ram_pkg::RBW_W0) ||
		(DATA_W == block_ram_pkg::RBW_W1) ||
		(DATA_W == block_ram_pkg::RBW_W2);

	logic [DATA_W-1:0] mem [DEPTH];
	logic [ADDR_W:0] wr_ptr_reg;
	logic [ADDR_W:0] rd_ptr_reg;
	logic [ADDR_W:0] wr_ptr_next;
	logic [ADDR_W:0] rd_ptr_next;
	logic [ADDR_W:0] wr_ptr_upd;
	logic [ADDR_W:0] rd_ptr_upd;
	logic [ADDR_W:0] level_upd;
	logic [ADDR_W:0] count;
	logic [ADDR_W:0] full_lvl;
	logic [ADDR_W:0] nfull_lvl;
	logic [ADDR_W:0] nempty_lvl;
	logic push_rise;
	logic pop_rise;
	logic push_ok;
	logic pop_ok;
	logic clr_a_n;
	logic clr_b_n;
	logic fifo_clear;
	logic fifo_rewind;
	logic full_flag_next;
	logic near_full_flag_next;
	logic near_empty_flag_next;
	logic empty_flag_next;
	block_ram_pkg::fifo_op_t fifo_op;

	// pin clocks are only sampled, never used as clocks, so every flop of
	// the block stays in the ref_clk domain; the price is three cycles of
	// latency and a pin clock well below ref_clk
	pin_sync push_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.ce(ce),
		.pin_in(push_clock),
		.level(),
		.rise(push_rise)
	);

	pin_sync pop_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.ce(ce),
		.pin_in(pop_clock),
		.level(),
		.rise(pop_rise)
	);

	// thresholds are clamped into their legal ranges
	always_comb begin
		full_lvl = full_level;
		if (full_lvl == ZERO_LVL) begin
			full_lvl = ONE;
		end else if (full_lvl > MAX_FULL) begin
			full_lvl = MAX_FULL;
		end
		nfull_lvl = near_full_level;
		if (nfull_lvl == ZERO_LVL) begin
			nfull_lvl = ONE;
		end else if (nfull_lvl >= full_lvl) begin
			nfull_lvl = full_lvl - ONE;
		end
		nempty_lvl = near_empty_level;
		if (nempty_lvl == ZERO_LVL) begin
			nempty_lvl = ONE;
		end else if (nempty_lvl >= full_lvl) begin
			nempty_lvl = full_lvl - ONE;
		end
	end

	assign fifo_clear = fifo_mode && port_a_reset;
	assign fifo_rewind = fifo_mode && port_b_reset;

	// pointers carry one extra bit so a full array and an empty one differ
	assign count = wr_ptr_reg - rd_ptr_reg;
	// guards use the live count so a stale flag never lets data be lost
	assign push_ok = fifo_mode && push_rise && push_clock_gate &&
		push_strobe && (count < full_lvl);
	// a pop that meets a pointer reset is dropped, so the reset wins and
	// no word leaves a fifo that is being emptied or rewound
	assign pop_ok = fifo_mode && pop_rise && pop_clock_gate &&
		pop_strobe && (count != ZERO_LVL) && !port_a_reset &&
		!port_b_reset;

	always_comb begin
		case ({pop_ok, push_ok})
			2'b01: fifo_op = block_ram_pkg::FIFO_PUSH;
			2'b10: fifo_op = block_ram_pkg::FIFO_POP;
			2'b11: fifo_op = block_ram_pkg::FIFO_BOTH;
			default: fifo_op = block_ram_pkg::FIFO_IDLE;
		endcase
	end

	always_comb begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		case (fifo_op)
			block_ram_pkg::FIFO_PUSH: begin
				wr_ptr_next = wr_ptr_reg + ONE;
			end
			block_ram_pkg::FIFO_POP: begin
				rd_ptr_next = rd_ptr_reg + ONE;
			end
			block_ram_pkg::FIFO_BOTH: begin
				wr_ptr_next = wr_ptr_reg + ONE;
				rd_ptr_next = rd_ptr_reg + ONE;
			end
			default: begin
				wr_ptr_next = wr_ptr_reg;
			end
		endcase
	end

	// pointers as they will stand after this cycle's resets; a flag that
	// updates in the cycle of a rewind must see the rewound level
	always_comb begin
		wr_ptr_upd = wr_ptr_next;
		rd_ptr_upd = rd_ptr_next;
		if (fifo_clear) begin
			wr_ptr_upd = '0;
			rd_ptr_upd = '0;
		end else if (fifo_rewind) begin
			rd_ptr_upd = '0;
		end
	end

	assign level_upd = wr_ptr_upd - rd_ptr_upd;

	always_comb begin
		full_flag_next = level_upd >= full_lvl;
		near_full_flag_next = level_upd >= nfull_lvl;
		near_empty_flag_next = level_upd <= nempty_lvl;
		empty_flag_next = level_upd ==
			(ADDR_W + 1)'(block_ram_pkg::EMPTY_LEVEL);
	end

	// write pointer: only a port-a reset clears it
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
		end else if (ce) begin
			if (fifo_mode && port_a_reset) begin
				wr_ptr_reg <= '0;
			end else begin
				wr_ptr_reg <= wr_ptr_next;
			end
		end
	end

	// read pointer: port-b reset rewinds it so stored words replay
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_ptr_reg <= '0;
		end else if (ce) begin
			if (fifo_mode && port_a_reset) begin
				rd_ptr_reg <= '0;
			end else if (fifo_mode && port_b_reset) begin
				rd_ptr_reg <= '0;
			end else begin
				rd_ptr_reg <= rd_ptr_next;
			end
		end
	end

	// push-side flags move only on a push clock edge or a fifo clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			full_flag <= block_ram_pkg::FULL_RST;
			near_full_flag <= block_ram_pkg::NEAR_FULL_RST;
		end else if (ce) begin
			if (fifo_mode && port_a_reset) begin
				full_flag <= block_ram_pkg::FULL_RST;
				near_full_flag <= block_ram_pkg::NEAR_FULL_RST;
			end else if (fifo_mode && push_rise) begin
				full_flag <= full_flag_next;
				near_full_flag <= near_full_flag_next;
			end
		end
	end

	// pop-side flags move only on a pop clock edge or a fifo clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			empty_flag <= block_ram_pkg::EMPTY_RST;
			near_empty_flag <= block_ram_pkg::NEAR_EMPTY_RST;
		end else if (ce) begin
			if (fifo_mode && port_a_reset) begin
				empty_flag <= block_ram_pkg::EMPTY_RST;
				near_empty_flag <= block_ram_pkg::NEAR_EMPTY_RST;
			end else if (fifo_mode && pop_rise) begin
				empty_flag <= empty_flag_next;
				near_empty_flag <= near_empty_flag_next;
			end
		end
	end

	// storage has no reset; a fifo clear only moves the pointers
	always_ff @(posedge ref_clk) begin
		if (ce) begin
			// fifo mode owns the array; ram port requests are ignored there
			if (fifo_mode) begin
				if (push_ok) begin
					mem[wr_ptr_reg[ADDR_W-1:0]] <= push_data;
				end
			end else begin
				if (en_a && we_a) begin
					mem[addr_a] <= wdata_a;
				end
				// same-address collision: port b wins
				if (en_b && we_b) begin
					mem[addr_b] <= wdata_b;
				end
			end
		end
	end

	// each port's output clears without a clock on its own reset
	assign clr_a_n = rst_b && !port_a_reset;
	assign clr_b_n = rst_b && !port_b_reset;

	always_ff @(posedge ref_clk or negedge clr_a_n) begin
		if (!clr_a_n) begin
			rdata_a <= '0;
		end else if (ce && !fifo_mode && en_a) begin
			if (!we_a) begin
				rdata_a <= mem[addr_a];
			end else begin
				case (write_mode_a)
					block_ram_pkg::WR_THROUGH: begin
						rdata_a <= wdata_a;
					end
					block_ram_pkg::WR_READ_FIRST: begin
						// other widths keep the output, as normal mode does
						if (RBW_OK) begin
							rdata_a <= mem[addr_a];
						end
					end
					default: begin
						rdata_a <= rdata_a;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge clr_b_n) begin
		if (!clr_b_n) begin
			rdata_b <= '0;
		end else if (ce && !fifo_mode && en_b) begin
			if (!we_b) begin
				rdata_b <= mem[addr_b];
			end else begin
				case (write_mode_b)
					block_ram_pkg::WR_THROUGH: begin
						rdata_b <= wdata_b;
					end
					block_ram_pkg::WR_READ_FIRST: begin
						if (RBW_OK) begin
							rdata_b <= mem[addr_b];
						end
					end
					default: begin
						rdata_b <= rdata_b;
					end
				endcase
			end
		end
	end

	// pop data sits behind the port-b output latch
	always_ff @(posedge ref_clk or negedge clr_b_n) begin
		if (!clr_b_n) begin
			pop_data <= '0;
		end else if (ce && pop_ok) begin
			pop_data <= mem[rd_ptr_reg[ADDR_W-1:0]];
		end
	end
endmodule

// ==== block_ram_fifo_asserts.sv ====
// Purpose: port checks for block_ram_fifo
// Assumes: one clock, rst_b low resets everything but the storage array
// Notes: flag edges are traced back through the three-flop pin sync
`timescale 1ns/10ps
module block_ram_fifo_asserts #(
	parameter int DATA_W = 9
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic fifo_mode,
	input wire logic [1:0] write_mode_a,
	input wire logic port_a_reset,
	input wire logic port_b_reset,
	input wire logic en_a,
	input wire logic we_a,
	input wire logic [DATA_W-1:0] wdata_a,
	input wire logic [DATA_W-1:0] rdata_a,
	input wire logic [DATA_W-1:0] rdata_b,
	input wire logic push_clock,
	input wire logic pop_clock,
	input wire logic full_flag,
	input wire logic near_full_flag,
	input wire logic near_empty_flag,
	input wire logic empty_flag
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic wr_a;
	assign wr_a = ce && en_a && we_a && !fifo_mode && !port_a_reset;
	// pin rose between the edges four and five cycles back
	sequence s_push_edge;
		!$past(push_clock, 5) && $past(push_clock, 4);
	endsequence
	sequence s_pop_edge;
		!$past(pop_clock, 5) && $past(pop_clock, 4);
	endsequence
	property p_clr_a; port_a_reset |-> rdata_a == '0; endproperty
	a_clr_a: assert property (p_clr_a) else $error("rdata_a kept");
	property p_clr_b; port_b_reset |-> rdata_b == '0; endproperty
	a_clr_b: assert property (p_clr_b) else $error("rdata_b kept");
	property p_thru;
		wr_a && write_mode_a == 2'h1 |=>
			port_a_reset || rdata_a == $past(wdata_a);
	endproperty
	a_thru: assert property (p_thru) else $error("no copy");
	property p_norm;
		wr_a && !write_mode_a[0] |=> port_a_reset || $stable(rdata_a);
	endproperty
	a_norm: assert property (p_norm) else $error("write shown");
	property p_fifo_clr;
		ce && fifo_mode && port_a_reset |=>
			{full_flag, near_full_flag, near_empty_flag, empty_flag} == 4'h3;
	endproperty
	a_fifo_clr: assert property (p_fifo_clr) else $error("flags kept");
	property p_full_rise; $rose(full_flag) |-> s_push_edge; endproperty
	a_full_rise: assert property (p_full_rise) else $error("full");
	property p_nf_rise; $rose(near_full_flag) |-> s_push_edge; endproperty
	a_nf_rise: assert property (p_nf_rise) else $error("near full");
	property p_empty_fell;
		$fell(empty_flag) |-> s_pop_edge;
	endproperty
	a_empty_fell: assert property (p_empty_fell) else $error("empty");
endmodule
bind block_ram_fifo block_ram_fifo_asserts #(.DATA_W(DATA_W)) u_chk (
	.ref_clk, .rst_b, .ce, .fifo_mode, .write_mode_a, .port_a_reset,
	.port_b_reset, .en_a, .we_a, .wdata_a, .rdata_a, .rdata_b, .push_clock,
	.pop_clock, .full_flag, .near_full_flag, .near_empty_flag, .empty_flag
);

// ==== fabric_side.sv ====
// Purpose: user logic driving the fifo push and pop pins
// Assumes: pin clocks are slow against ref_clk
// Notes: pin clocks stand low between words
`timescale 1ns/10ps
module fabric_side #(
	parameter int DATA_W = 9
) (
	input wire logic ref_clk,
	output logic push_clock,
	output logic push_clock_gate,
	output logic push_strobe,
	output logic [DATA_W-1:0] push_data,
	output logic pop_clock,
	output logic pop_clock_gate,
	output logic pop_strobe,
	input wire logic [DATA_W-1:0] pop_data
);
	initial begin
		{push_clock, push_clock_gate, push_strobe, push_data} = '0;
		{pop_clock, pop_clock_gate, pop_strobe} = '0;
	end
	// controls held over the whole high phase; slow stretches it
	task push(input logic [DATA_W-1:0] v, input logic [1:0] slow);
		@(posedge ref_clk);
		{push_clock, push_clock_gate, push_strobe} <= 3'h7;
		push_data <= v;
		repeat (3 + slow) @(posedge ref_clk);
		push_clock <= 1'b0;
		repeat (4) @(posedge ref_clk);
		{push_clock_gate, push_strobe} <= 2'h0;
		push_data <= ~v;
		@(negedge ref_clk);
	endtask
	// one word per pop, so the bench knows exactly what a replay gives
	task pop(output logic [DATA_W-1:0] v);
		@(posedge ref_clk);
		{pop_clock, pop_clock_gate, pop_strobe} <= 3'h7;
		repeat (3) @(posedge ref_clk);
		pop_clock <= 1'b0;
		repeat (4) @(posedge ref_clk);
		{pop_clock_gate, pop_strobe} <= 2'h0;
		@(negedge ref_clk);
		v = pop_data;
	endtask
endmodule

// ==== test_block_ram_fifo.sv ====
// Purpose: directed test of ram write modes, output clears and fifo
// Assumes: fabric_side drives the fifo pins
// Notes: an eight-word fifo keeps the run short
`timescale 1ns/10ps
module test_block_ram_fifo;
	localparam int DW = 9;
	localparam int AW = 3;
	logic ref_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, fifo_mode = 1'b0;
	logic [1:0] write_mode_a = 2'h0, write_mode_b = 2'h0;
	logic port_a_reset = 1'b0, port_b_reset = 1'b0;
	logic en_a = 1'b0, we_a = 1'b0, en_b = 1'b0, we_b = 1'b0;
	logic [AW-1:0] addr_a = '0, addr_b = '0;
	logic [DW-1:0] wdata_a = '0, wdata_b = '0, rdata_a, rdata_b;
	logic [DW-1:0] push_data, pop_data, d;
	logic push_clock, push_clock_gate, push_strobe;
	logic pop_clock, pop_clock_gate, pop_strobe;
	logic full_flag, near_full_flag, near_empty_flag, empty_flag;
	logic [AW:0] full_level = 4'h4, near_full_level = 4'h3;
	logic [AW:0] near_empty_level = 4'h1;
	int n_mismatch = 0, num_checks = 0;
	initial forever #50 ref_clk = ~ref_clk;
	block_ram_fifo #(.DATA_W(DW), .ADDR_W(AW)) u_dut (.ref_clk, .rst_b,
		.ce, .fifo_mode, .write_mode_a, .write_mode_b, .port_a_reset,
		.port_b_reset, .en_a, .we_a, .addr_a, .wdata_a, .rdata_a, .en_b,
		.we_b, .addr_b, .wdata_b, .rdata_b, .push_clock, .push_clock_gate,
		.push_strobe, .push_data, .pop_clock, .pop_clock_gate, .pop_strobe,
		.pop_data, .full_level, .near_full_level, .near_empty_level,
		.full_flag, .near_full_flag, .near_empty_flag, .empty_flag);
	fabric_side #(.DATA_W(DW)) u_fab (.ref_clk, .push_clock,
		.push_clock_gate, .push_strobe, .push_data, .pop_clock,
		.pop_clock_gate, .pop_strobe, .pop_data);
	task chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one-cycle access on port a or b; returns mid-cycle after it
	task acc(input logic pb, w, input logic [AW-1:0] a,
		input logic [DW-1:0] v);
		@(posedge ref_clk);
		{en_a, we_a, addr_a, wdata_a} <= {!pb, w, a, v};
		{en_b, we_b, addr_b, wdata_b} <= {pb, w, a, v};
		@(posedge ref_clk);
		{en_a, en_b} <= 2'h0;
		@(negedge ref_clk);
	endtask
	task print_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#500000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		acc(0, 1, 3'h1, 9'h0a5);
		acc(0, 0, 3'h1, 9'h000);
		chk(rdata_a, 9'h0a5);
		acc(0, 1, 3'h2, 9'h15a);
		chk(rdata_a, 9'h0a5);
		@(posedge ref_clk) write_mode_a <= 2'h1;
		acc(0, 1, 3'h3, 9'h1c3);
		chk(rdata_a, 9'h1c3);
		@(posedge ref_clk) write_mode_a <= 2'h3;
		acc(0, 1, 3'h1, 9'h033);
		chk(rdata_a, 9'h0a5);
		acc(1, 1, 3'h4, 9'h0f0);
		chk(rdata_b, 9'h000);
		@(posedge ref_clk) write_mode_b <= 2'h1;
		acc(1, 1, 3'h5, 9'h0c5);
		chk(rdata_b, 9'h0c5);
		acc(1, 0, 3'h1, 9'h000);
		chk(rdata_b, 9'h033);
		acc(0, 0, 3'h4, 9'h000);
		chk(rdata_a, 9'h0f0);
		@(posedge ref_clk) ce <= 1'b0;
		acc(0, 1, 3'h4, 9'h1ff);
		@(posedge ref_clk) ce <= 1'b1;
		acc(0, 0, 3'h4, 9'h000);
		chk(rdata_a, 9'h0f0);
		@(posedge ref_clk) port_a_reset <= 1'b1;
		#1 chk(rdata_a, 9'h000);
		chk(rdata_b, 9'h033);
		@(posedge ref_clk) {port_a_reset, port_b_reset} <= 2'h1;
		#1 chk(rdata_b, 9'h000);
		@(posedge ref_clk) {fifo_mode, port_a_reset, port_b_reset} <= 3'h6;
		@(posedge ref_clk) port_a_reset <= 1'b0;
		@(negedge ref_clk);
		chk({full_flag, near_full_flag, near_empty_flag, empty_flag}, 4'h3);
		// the fifth push must be refused with the level at four
		for (int i = 1; i <= 5; i++) begin
			u_fab.push(DW'(i * 9'h011), 2'(i));
			if (i >= 3) chk({full_flag, near_full_flag}, {i >= 4, 1'b1});
		end
		for (int i = 1; i <= 5; i++) begin
			u_fab.pop(d);
			chk(d, DW'((i > 4 ? 4 : i) * 9'h011));
		end
		chk({near_empty_flag, empty_flag}, 2'h3);
		@(posedge ref_clk) port_b_reset <= 1'b1;
		@(posedge ref_clk) port_b_reset <= 1'b0;
		u_fab.pop(d);
		chk(d, 9'h011);
		chk({near_empty_flag, empty_flag}, 2'h0);
		@(posedge ref_clk) port_a_reset <= 1'b1;
		@(posedge ref_clk) port_a_reset <= 1'b0;
		u_fab.pop(d);
		chk(empty_flag, 1'b1);
		chk(d, 9'h011);
		@(posedge ref_clk) rst_b <= 1'b0;
		#1 chk(pop_data, 9'h000);
		@(posedge ref_clk) rst_b <= 1'b1;
		@(negedge ref_clk);
		print_verdict;
	end
endmodule
